// ### design/abx_map.vh
// Notes on behaviour
// - and-with-register: W AND f, d picks destination
// - and-with-register updates only negative and zero
// - access bit 0 access bank, 1 bank selector
// - a=0, extended, f<=5Fh: indexed literal offset
// - bit-clear zeroes bit b, flags untouched
// - branch_on_carry branches only when carry set
// - branch_on_negative branches only when negative set
// - branch_on_no_carry branches only when carry clear
// - branch_on_non_negative branches only when negative clear
// - branch_on_no_overflow branches only when overflow clear
// - branch_on_nonzero branches only when zero clear
// - taken branch: counter becomes counter+2+2n
// - taken two cycles, second idle; untaken no write
`ifndef ABX_MAP_VH
`define ABX_MAP_VH
// opcode fields
`define ABX_OP_AND 6'h05
`define ABX_OP_BCLR 4'h9
`define ABX_OP_BC 8'hE2
`define ABX_OP_BN 8'hE6
`define ABX_OP_BNC 8'hE3
`define ABX_OP_BNN 8'hE7
`define ABX_OP_BRANCH_ON_NO_OVERFLOW 8'hE5
`define ABX_OP_BNZ 8'hE1
// operand addressing
`define ABX_ILO_MAX 8'h5F
`define ABX_ACC_SPLIT 8'h80
`define ABX_ACC_HI_BANK 4'hF
`define ABX_ACC_LO_BANK 4'h0
// program counter step per word, in bytes
`define ABX_PC_STEP 16'h0002
// instruction phases
`define ABX_Q1 2'h0
`define ABX_Q2 2'h1
`define ABX_Q3 2'h2
`define ABX_Q4 2'h3
// status bit positions
`define ABX_ST_C 0
`define ABX_ST_DC 1
`define ABX_ST_Z 2
`define ABX_ST_OV 3
`define ABX_ST_N 4
// control bit positions
`define ABX_CTRL_RUN 0
`define ABX_CTRL_EXT 1
// register byte offsets
`define ABX_REG_CTRL 8'h00
`define ABX_REG_WORK 8'h04
`define ABX_REG_BANK 8'h08
`define ABX_REG_STATUS 8'h0C
`define ABX_REG_PC 8'h10
`define ABX_REG_IDX 8'h14
`define ABX_REG_STATE 8'h18
// reset values
`define ABX_RST_CTRL 2'h0
`define ABX_RST_WORK 8'h00
`define ABX_RST_BANK 4'h0
`define ABX_RST_STATUS 5'h00
`define ABX_RST_PC 16'h0000
`define ABX_RST_IDX 12'h000
`define ABX_RST_INSTR 16'h0000
// bus responses
`define ABX_RESP_OKAY 2'h0
`define ABX_RESP_SLVERR 2'h2
`endif

// ### design/abx_qphase.v
`timescale 1ns/100ps
// four-phase sequencer; each phase lasts one clock while running
module abx_qphase (
   // clock and reset
   input wire clk_sys_i,
   input wire srst_i,
   // control
   input wire run_i,
   // phase number
   output reg [1:0] phase_o
);
`include "abx_map.vh"

   // phase advances only while running, so a stop freezes mid instruction
   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         phase_o <= `ABX_Q1;
      end else if (run_i) begin
         phase_o <= phase_o + 2'h1;
      end
   end
endmodule // abx_qphase

// ### design/abx_decode.v
`timescale 1ns/100ps
// combinational decode and execute for and, bit-clear and branches
module abx_decode (
   // instruction and context
   input wire [15:0] word_i,
   input wire [7:0] work_i,
   input wire [7:0] rdata_i,
   input wire [4:0] status_i,
   input wire [15:0] pc_i,
   input wire [3:0] bank_i,
   input wire [11:0] idx_base_i,
   input wire ext_en_i,
   // decoded kind
   output wire is_and_o,
   output wire is_bclr_o,
   output wire is_br_o,
   output wire dest_mem_o,
   // results
   output wire [11:0] addr_o,
   output reg [7:0] result_o,
   output wire [4:0] status_o,
   output wire taken_o,
   output wire [15:0] target_o
);
`include "abx_map.vh"

   // operand address from access bit, file byte and mode
   function [11:0] resolve;
      input a;
      input [7:0] f;
      input ext;
      input [3:0] bank;
      input [11:0] base;
      begin
         if (a)
            resolve = {bank, f};
         else if (ext && (f <= `ABX_ILO_MAX))
            resolve = base + {4'h0, f};
         else if (f < `ABX_ACC_SPLIT)
            resolve = {`ABX_ACC_LO_BANK, f};
         else
            resolve = {`ABX_ACC_HI_BANK, f};
      end
   endfunction

   // branch condition for a high opcode byte; unknown bytes never branch
   function br_cond;
      input [7:0] op;
      input [4:0] st;
      begin
         case (op)
            `ABX_OP_BC: br_cond = st[`ABX_ST_C];
            `ABX_OP_BN: br_cond = st[`ABX_ST_N];
            `ABX_OP_BNC: br_cond = ~st[`ABX_ST_C];
            `ABX_OP_BNN: br_cond = ~st[`ABX_ST_N];
            `ABX_OP_BRANCH_ON_NO_OVERFLOW: br_cond = ~st[`ABX_ST_OV];
            `ABX_OP_BNZ: br_cond = ~st[`ABX_ST_Z];
            default: br_cond = 1'b0;
         endcase
      end
   endfunction

   wire [7:0] op_hi; // high opcode byte
   wire [7:0] lit; // file byte or signed offset
   assign op_hi = word_i[15:8];
   assign lit = word_i[7:0];

   assign is_and_o = (word_i[15:10] == `ABX_OP_AND);
   assign is_bclr_o = (word_i[15:12] == `ABX_OP_BCLR);
   assign is_br_o = (op_hi == `ABX_OP_BC) || (op_hi == `ABX_OP_BN) ||
                    (op_hi == `ABX_OP_BNC) || (op_hi == `ABX_OP_BNN) ||
                    (op_hi == `ABX_OP_BRANCH_ON_NO_OVERFLOW) || (op_hi == `ABX_OP_BNZ);
   assign dest_mem_o = word_i[9];
   assign addr_o = resolve(word_i[8], lit, ext_en_i, bank_i, idx_base_i);

   // processed data for the write phase
   always @* begin
      result_o = rdata_i;
      if (is_and_o)
         result_o = work_i & rdata_i;
      else if (is_bclr_o)
         result_o = rdata_i & ~(8'h01 << word_i[11:9]);
   end

   // only negative and zero follow the and result
   assign status_o = {result_o[7], status_i[`ABX_ST_OV], (result_o == 8'h00),
                      status_i[`ABX_ST_DC], status_i[`ABX_ST_C]};

   // counter was already stepped in decode, so target is pc+2+2n
   assign taken_o = is_br_o && br_cond(op_hi, status_i);
   assign target_o = pc_i + {{7{lit[7]}}, lit, 1'b0};
endmodule // abx_decode

// ### design/abx_core.v
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
// execution core with an axi4-lite register slave
module abx_core (
   // clock and reset
   input wire clk_sys_i,
   input wire srst_i,
   // axi4-lite write address
   input wire [7:0] s_axi_awaddr_i,
   input wire s_axi_awvalid_i,
   output wire s_axi_awready_o,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata_i,
   input wire [3:0] s_axi_wstrb_i,
   input wire s_axi_wvalid_i,
   output wire s_axi_wready_o,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp_o,
   output reg s_axi_bvalid_o,
   input wire s_axi_bready_i,
   // axi4-lite read address
   input wire [7:0] s_axi_araddr_i,
   input wire s_axi_arvalid_i,
   output wire s_axi_arready_o,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata_o,
   output reg [1:0] s_axi_rresp_o,
   output reg s_axi_rvalid_o,
   input wire s_axi_rready_i,
   // program fetch
   output wire [15:0] fetch_addr_o,
   input wire [15:0] instr_i,
   // data memory
   output reg [11:0] dmem_addr_o,
   output wire dmem_rd_o,
   input wire [7:0] dmem_rdata_i,
   output wire dmem_wr_o,
   output reg [7:0] dmem_wdata_o
);
`include "abx_map.vh"

   // merge strobed bytes into an old word
   function [31:0] wmerge;
      input [31:0] old;
      input [31:0] data;
      input [3:0] strb;
      integer i;
      begin
         wmerge = old;
         for (i = 0; i < 4; i = i + 1)
            if (strb[i])
               wmerge[i*8 +: 8] = data[i*8 +: 8];
      end
   endfunction

   // every register resets on the clock; there is no asynchronous path
   // software-visible state
   reg run; // core advances only while set
   reg ext_en; // extended instruction set enable
   reg [7:0] work; // working register
   reg [3:0] bank_selector; // bank for a=1 operands
   reg [4:0] status; // carry, digit carry, zero, overflow_flag, negative
   reg [15:0] program_counter; // byte address of next fetch
   reg [11:0] idx_base; // base for indexed literal offset
   // instruction state
   reg [15:0] instr; // word under execution
   reg flush; // current cycle is the idle second cycle of a branch
   reg [7:0] rdata_q; // operand read in the read phase
   // bus state
   // one write slot: each half waits here until the other has arrived
   reg aw_held; // write address taken, waiting for data
   reg w_held; // write data taken, waiting for address
   reg [7:0] aw_addr_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;

   // datapath nets
   wire [1:0] phase; // current phase
   wire [15:0] dec_word; // word seen by the decoder
   wire is_and;
   wire is_bclr;
   wire is_br;
   wire dest_mem;
   wire [11:0] op_addr;
   wire [7:0] result;
   wire [4:0] next_status;
   wire taken;
   wire [15:0] target;
   wire do_wr; // both write halves present
   wire aw_hs;
   wire w_hs;
   wire ar_hs;
   wire [31:0] wr_word; // old value merged with strobed data
   // address decode, combinational
   reg [31:0] rd_word; // read mux
   reg rd_hit; // read address is mapped
   reg [31:0] old_word; // current value at the write address
   reg wr_hit; // write address is mapped

   // phase sequencer
   abx_qphase u_qphase (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .run_i(run),
      .phase_o(phase)
   );

   // decode the incoming word in decode phase so the address is ready for read
   assign dec_word = (phase == `ABX_Q1) ? instr_i : instr;

   // decode and execute datapath
   // the decoder holds no state; every register of the core lives here, except the phase, which the sequencer holds
   abx_decode u_decode (
      .word_i(dec_word),
      .work_i(work),
      .rdata_i(rdata_q),
      .status_i(status),
      .pc_i(program_counter),
      .bank_i(bank_selector),
      .idx_base_i(idx_base),
      .ext_en_i(ext_en),
      .is_and_o(is_and),
      .is_bclr_o(is_bclr),
      .is_br_o(is_br),
      .dest_mem_o(dest_mem),
      .addr_o(op_addr),
      .result_o(result),
      .status_o(next_status),
      .taken_o(taken),
      .target_o(target)
   );

   // fetch address is the counter itself, always word aligned
   assign fetch_addr_o = program_counter;
   // read strobe in read phase, write strobe in write phase
   assign dmem_rd_o = run && !flush && (phase == `ABX_Q2) && (is_and || is_bclr);
   assign dmem_wr_o = run && !flush && (phase == `ABX_Q4) &&
                      (is_bclr || (is_and && dest_mem));

   // bus handshakes; one write and one read in flight at most
   // a waiting response blocks both write halves, which keeps writes in order
   assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
   assign s_axi_wready_o = !w_held && !s_axi_bvalid_o;
   assign s_axi_arready_o = !s_axi_rvalid_o;
   assign aw_hs = s_axi_awvalid_i && s_axi_awready_o;
   assign w_hs = s_axi_wvalid_i && s_axi_wready_o;
   assign ar_hs = s_axi_arvalid_i && s_axi_arready_o;
   assign do_wr = aw_held && w_held && !s_axi_bvalid_o;
   assign wr_word = wmerge(old_word, w_data_q, w_strb_q);

   // register read mux shared by the read and write paths
   // unmapped addresses read zero and report a miss, answered with a slave error
   function [32:0] regmux;
      input [7:0] a;
      reg [31:0] v;
      reg hit;
      begin
         v = 32'h00000000;
         hit = 1'b1;
         case (a)
            `ABX_REG_CTRL: v = {30'h00000000, ext_en, run};
            `ABX_REG_WORK: v = {24'h000000, work};
            `ABX_REG_BANK: v = {28'h0000000, bank_selector};
            `ABX_REG_STATUS: v = {27'h0000000, status};
            `ABX_REG_PC: v = {16'h0000, program_counter};
            `ABX_REG_IDX: v = {20'h00000, idx_base};
            `ABX_REG_STATE: v = {13'h0000, flush, phase, instr};
            default: hit = 1'b0;
         endcase
         regmux = {hit, v};
      end
   endfunction

   // decode read and write addresses
   always @* begin
      {rd_hit, rd_word} = regmux(s_axi_araddr_i);
      {wr_hit, old_word} = regmux(aw_addr_q);
   end

   // write channel capture and response
   // a miss still answers, with a slave error, and changes nothing
   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= `ABX_RESP_OKAY;
      end else begin
         // address and data may arrive in either order
         if (aw_hs) begin
            aw_held <= 1'b1;
            aw_addr_q <= s_axi_awaddr_i;
         end
         if (w_hs) begin
            w_held <= 1'b1;
            w_data_q <= s_axi_wdata_i;
            w_strb_q <= s_axi_wstrb_i;
         end
         if (do_wr) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= wr_hit ? `ABX_RESP_OKAY : `ABX_RESP_SLVERR;
         end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
         end
      end
   end

   // read channel: data one cycle after the address is taken
   // arready drops while data waits, so a second read cannot overtake the first
   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h00000000;
         s_axi_rresp_o <= `ABX_RESP_OKAY;
      end else if (ar_hs) begin
         s_axi_rvalid_o <= 1'b1;
         s_axi_rdata_o <= rd_word;
         s_axi_rresp_o <= rd_hit ? `ABX_RESP_OKAY : `ABX_RESP_SLVERR;
      end else if (s_axi_rready_i) begin
         s_axi_rvalid_o <= 1'b0;
      end
   end

   // software writes first, core updates after so the core wins a clash
   // a clash drops the bus write; software is expected to write while stopped
   always @(posedge clk_sys_i) begin
      if (srst_i) begin
         {ext_en, run} <= `ABX_RST_CTRL;
         work <= `ABX_RST_WORK;
         bank_selector <= `ABX_RST_BANK;
         status <= `ABX_RST_STATUS;
         program_counter <= `ABX_RST_PC;
         idx_base <= `ABX_RST_IDX;
         instr <= `ABX_RST_INSTR;
         flush <= 1'b0;
         rdata_q <= 8'h00;
         dmem_addr_o <= 12'h000;
         dmem_wdata_o <= 8'h00;
      end else begin
         if (do_wr) begin
            case (aw_addr_q)
               `ABX_REG_CTRL: begin
                  run <= wr_word[`ABX_CTRL_RUN];
                  ext_en <= wr_word[`ABX_CTRL_EXT];
               end
               `ABX_REG_WORK: work <= wr_word[7:0];
               `ABX_REG_BANK: bank_selector <= wr_word[3:0];
               `ABX_REG_STATUS: status <= wr_word[4:0];
               // word aligned: the low byte bit is forced to zero
               `ABX_REG_PC: program_counter <= {wr_word[15:1], 1'b0};
               `ABX_REG_IDX: idx_base <= wr_word[11:0];
               default: ;
            endcase
         end
         if (run) begin
            case (phase)
               `ABX_Q1: begin
                  // idle second cycle of a taken branch fetches nothing; the counter
                  // already holds the target, which is fetched one cycle later
                  if (!flush) begin
                     instr <= instr_i;
                     dmem_addr_o <= op_addr;
                     program_counter <= program_counter + `ABX_PC_STEP;
                  end
               end
               `ABX_Q2: begin
                  // only and and bit-clear read; branches and the idle cycle do not
                  if (dmem_rd_o)
                     rdata_q <= dmem_rdata_i;
               end
               `ABX_Q3: begin
                  // latched so the write phase drives a settled byte
                  dmem_wdata_o <= result;
               end
               `ABX_Q4: begin
                  if (flush) begin
                     // the idle cycle ends only here: the branch word still sits in
                     // instr and must not be executed a second time
                     flush <= 1'b0;
                  end else begin
                     if (is_and) begin
                        // carry, digit carry and overflow keep their values
                        status <= next_status;
                        if (!dest_mem)
                           work <= dmem_wdata_o;
                     end
                     // untaken branch writes nothing here
                     if (taken) begin
                        program_counter <= target;
                        flush <= 1'b1;
                     end
                  end
               end
               default: ;
            endcase
         end
      end
   end
endmodule // abx_core

// ### testbench/abx_core_properties.sv
`timescale 1ns/100ps
`include "abx_map.vh"
// port checks; the word fetched at a phase-1 edge is still on instr_i when that edge samples
module abx_core_properties (
   // clock and reset
   input wire clk_sys_i,
   input wire srst_i,
   // register bus
   input wire s_axi_awvalid_i,
   input wire s_axi_awready_o,
   input wire s_axi_wvalid_i,
   input wire s_axi_wready_o,
   input wire [1:0] s_axi_bresp_o,
   input wire s_axi_bvalid_o,
   input wire s_axi_bready_i,
   input wire s_axi_arvalid_i,
   input wire s_axi_arready_o,
   input wire [31:0] s_axi_rdata_o,
   input wire s_axi_rvalid_o,
   input wire s_axi_rready_i,
   // fetch and data memory
   input wire [15:0] fetch_addr_o,
   input wire [15:0] instr_i,
   input wire [11:0] dmem_addr_o,
   input wire dmem_rd_o,
   input wire [7:0] dmem_rdata_i,
   input wire dmem_wr_o,
   input wire [7:0] dmem_wdata_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   // a jump: the counter moves, not by one word, four edges after a branch word was fetched
   sequence jump_s;
      !$past(srst_i) && fetch_addr_o != $past(fetch_addr_o)
         && fetch_addr_o != $past(fetch_addr_o) + 16'h0002 && $past(instr_i[15:12], 4) == 4'hE;
   endsequence
   a_br_target: assert property (jump_s |-> fetch_addr_o == $past(fetch_addr_o)
      + {{7{$past(instr_i[7], 4)}}, $past(instr_i[7:0], 4), 1'b0}) else $error("bad target");
   a_br_idle: assert property (jump_s |=> $stable(fetch_addr_o) [*4])
      else $error("fetch in idle cycle");
   a_rd_pulse: assert property (dmem_rd_o |=> !dmem_rd_o [*3])
      else $error("read strobe repeats");
   // branches never touch data memory
   a_rd_kind: assert property (dmem_rd_o |-> $past(instr_i[15:12]) == 4'h9
      || $past(instr_i[15:10]) == 6'h05) else $error("read for wrong kind");
   a_wr_kind: assert property (dmem_wr_o |-> $past(dmem_rd_o, 2)
      && $stable(dmem_addr_o) && ($past(instr_i[15:12], 3) == 4'h9
      || $past(instr_i[15:9], 3) == 7'h0B)) else $error("write for wrong kind");
   a_bclr_value: assert property (dmem_wr_o && $past(instr_i[15:12], 3) == 4'h9
      |-> dmem_wdata_o == ($past(dmem_rdata_i, 2) & ~(8'h01 << $past(instr_i[11:9], 3))))
      else $error("bit clear value");
   a_b_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
      |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");
   a_r_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
      |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data dropped");
   a_b_time: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
      && s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("write response late");
   a_r_time: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read data late");
   // main scenarios reached
   c_jump: cover property (jump_s);
   c_write: cover property (dmem_wr_o);
   c_slverr: cover property (s_axi_bvalid_o && s_axi_bresp_o == `ABX_RESP_SLVERR);
endmodule // abx_core_properties

bind abx_core abx_core_properties u_prop (.clk_sys_i, .srst_i, .s_axi_awvalid_i,
   .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
   .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o,
   .s_axi_rready_i, .fetch_addr_o, .instr_i, .dmem_addr_o, .dmem_rd_o, .dmem_rdata_i,
   .dmem_wr_o, .dmem_wdata_o);

// ### testbench/abx_mem_model.sv
`timescale 1ns/100ps
// program words and data registers beside the core; reads are combinational
module abx_mem_model (
   // clock
   input wire clk_sys_i,
   // program fetch
   input wire [15:0] fetch_addr_i,
   output wire [15:0] instr_o,
   // data memory
   input wire [11:0] addr_i,
   input wire rd_i,
   output logic [7:0] rdata_o,
   input wire wr_i,
   input wire [7:0] wdata_i
);
   logic [15:0] rom [0:255]; // small program space, wraps, loaded by the bench
   logic [7:0] ram [0:4095]; // unwritten cells read unknown, so a wrong address shows
   logic [7:0] last = 8'h00; // last value driven while reading
   assign instr_o = rom[fetch_addr_i[8:1]];
   // outside the strobe the data shows the inverse of its last value, never a stale match
   always_comb rdata_o = rd_i ? ram[addr_i] : ~last;
   // capture and write on the rising edge
   always @(posedge clk_sys_i) begin
      if (rd_i) last <= ram[addr_i];
      if (wr_i) ram[addr_i] <= wdata_i;
   end
endmodule // abx_mem_model

// ### testbench/and_bitclear_branch_exec_test.sv
`timescale 1ns/100ps
`include "abx_map.vh"
// table of single instructions, then reset values and unmapped bus places
module and_bitclear_branch_exec_test;
   // one instruction, its context and what it should leave behind
   typedef struct packed {
      logic [15:0] instr;
      logic ext;
      logic [7:0] w, st, m;
      logic [11:0] addr;
      logic [7:0] ew, em, est;
      logic [15:0] epc;
   } abx_row_t;
   abx_row_t rows [0:13] = '{
      '{16'h1542, 1'b1, 8'h17, 8'h13, 8'hC2, 12'h342, 8'h02, 8'hC2, 8'h03, 16'h0002},
      '{16'h165F, 1'b1, 8'h0F, 8'h11, 8'hF0, 12'h25F, 8'h0F, 8'h00, 8'h05, 16'h0002},
      '{16'h1480, 1'b1, 8'hFF, 8'h04, 8'h81, 12'hF80, 8'h81, 8'h81, 8'h10, 16'h0002},
      '{16'h145F, 1'b0, 8'h3C, 8'h00, 8'h3C, 12'h05F, 8'h3C, 8'h3C, 8'h00, 16'h0002},
      '{16'h9E90, 1'b1, 8'h55, 8'h07, 8'hC7, 12'hF90, 8'h55, 8'h47, 8'h07, 16'h0002},
      '{16'h9110, 1'b1, 8'h55, 8'h17, 8'hFF, 12'h310, 8'h55, 8'hFE, 8'h17, 16'h0002},
      '{16'hE205, 1'b1, 8'h55, 8'h01, 8'h5A, 12'hFFF, 8'h55, 8'h5A, 8'h01, 16'h000C},
      '{16'hE205, 1'b1, 8'h55, 8'h00, 8'h5A, 12'hFFF, 8'h55, 8'h5A, 8'h00, 16'h0002},
      '{16'hE680, 1'b1, 8'h55, 8'h10, 8'h5A, 12'hFFF, 8'h55, 8'h5A, 8'h10, 16'hFF02},
      '{16'hE37F, 1'b1, 8'h55, 8'h00, 8'h5A, 12'hFFF, 8'h55, 8'h5A, 8'h00, 16'h0100},
      '{16'hE703, 1'b1, 8'h55, 8'h10, 8'h5A, 12'hFFF, 8'h55, 8'h5A, 8'h10, 16'h0002},
      '{16'hE503, 1'b1, 8'h55, 8'h08, 8'h5A, 12'hFFF, 8'h55, 8'h5A, 8'h08, 16'h0002},
      '{16'hE101, 1'b1, 8'h55, 8'h00, 8'h5A, 12'hFFF, 8'h55, 8'h5A, 8'h00, 16'h0004},
      '{16'hE101, 1'b1, 8'h55, 8'h04, 8'h5A, 12'hFFF, 8'h55, 8'h5A, 8'h04, 16'h0002}};
   logic clk_sys_i = 1'b0, srst_i = 1'b1; // reset held from time zero
   logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
   logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
   logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
   logic [31:0] s_axi_wdata_i = 32'h0;
   logic [3:0] s_axi_wstrb_i = 4'hF; // whole words, except in the low-lane write test
   wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
   wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
   wire [31:0] s_axi_rdata_o;
   wire [15:0] fetch_addr_o, instr_i;
   wire [11:0] dmem_addr_o;
   wire dmem_rd_o, dmem_wr_o;
   wire [7:0] dmem_rdata_i, dmem_wdata_o;
   int mismatches = 0, n_tests = 0;
   abx_core DUT (.clk_sys_i, .srst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
      .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
      .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
      .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .fetch_addr_o,
      .instr_i, .dmem_addr_o, .dmem_rd_o, .dmem_rdata_i, .dmem_wr_o, .dmem_wdata_o);
   abx_mem_model u_mem (.clk_sys_i(clk_sys_i), .fetch_addr_i(fetch_addr_o), .instr_o(instr_i),
      .addr_i(dmem_addr_o), .rd_i(dmem_rd_o), .rdata_o(dmem_rdata_i), .wr_i(dmem_wr_o),
      .wdata_i(dmem_wdata_o));
   // 40 MHz
   always #12.5 clk_sys_i = ~clk_sys_i;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      $display("compares %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // readies are looked at mid-cycle, where they equal what the next edge samples
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic pa, pw, ta, tw;
      pa = 1'b1;
      pw = 1'b1;
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      while (pa || pw) begin
         @(negedge clk_sys_i);
         ta = pa && s_axi_awready_o === 1'b1;
         tw = pw && s_axi_wready_o === 1'b1;
         @(posedge clk_sys_i);
         if (ta) s_axi_awvalid_i <= 1'b0;
         if (tw) s_axi_wvalid_i <= 1'b0;
         pa = pa && !ta;
         pw = pw && !tw;
      end
      do @(negedge clk_sys_i); while (s_axi_bvalid_o !== 1'b1);
      @(posedge clk_sys_i);
      s_axi_bready_i <= 1'b1; // late ready lets the response stand a cycle
      @(negedge clk_sys_i);
      r = s_axi_bresp_o; // as the accepting edge will sample it
      @(posedge clk_sys_i);
      s_axi_bready_i <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      do @(negedge clk_sys_i); while (s_axi_arready_o !== 1'b1);
      @(posedge clk_sys_i);
      s_axi_arvalid_i <= 1'b0;
      do @(negedge clk_sys_i); while (s_axi_rvalid_o !== 1'b1);
      @(posedge clk_sys_i);
      s_axi_rready_i <= 1'b1;
      @(negedge clk_sys_i);
      d = s_axi_rdata_o;
      r = s_axi_rresp_o;
      @(posedge clk_sys_i);
      s_axi_rready_i <= 1'b0;
   endtask
   // every other word is a branch to itself, so the counter parks after the instruction
   task automatic run_row(input abx_row_t r);
      logic [31:0] v;
      logic [1:0] s;
      for (int i = 0; i < 256; i++) u_mem.rom[i] = r.st[`ABX_ST_OV] ? 16'hE1FF : 16'hE5FF;
      u_mem.rom[0] = r.instr;
      u_mem.ram[r.addr] = r.m;
      srst_i <= 1'b1;
      @(posedge clk_sys_i);
      srst_i <= 1'b0;
      axi_wr(`ABX_REG_WORK, {24'h0, r.w}, s);
      axi_wr(`ABX_REG_STATUS, {24'h0, r.st}, s);
      axi_wr(`ABX_REG_BANK, 32'h3, s);
      axi_wr(`ABX_REG_IDX, 32'h200, s);
      axi_wr(`ABX_REG_CTRL, {30'h0, r.ext, 1'b1}, s);
      // far beyond the two instruction cycles of the longest case
      repeat (40) @(posedge clk_sys_i);
      axi_wr(`ABX_REG_CTRL, 32'h0, s);
      axi_rd(`ABX_REG_WORK, v, s);
      chk(v, {24'h0, r.ew});
      axi_rd(`ABX_REG_STATUS, v, s);
      chk(v, {24'h0, r.est});
      axi_rd(`ABX_REG_PC, v, s);
      // stopped between the parked word's own fetch and its jump back
      if (v === {16'h0, r.epc + 16'h2}) v = v - 32'h2;
      chk(v, {16'h0, r.epc});
      chk({24'h0, u_mem.ram[r.addr]}, {24'h0, r.em});
   endtask
   // main sequence
   initial begin
      logic [31:0] v;
      logic [1:0] s;
      // the first row's own reset edge is the twelfth
      repeat (11) @(posedge clk_sys_i);
      foreach (rows[k]) run_row(rows[k]);
      // reset values of the whole map
      srst_i <= 1'b1;
      @(posedge clk_sys_i);
      srst_i <= 1'b0;
      for (logic [7:0] a = 8'h00; a < 8'h1C; a += 8'h04) begin
         axi_rd(a, v, s);
         chk(v, 32'h0);
      end
      // a write without the low lane leaves the work register alone
      s_axi_wstrb_i <= 4'hE;
      axi_wr(`ABX_REG_WORK, 32'h000000FF, s);
      axi_rd(`ABX_REG_WORK, v, s);
      chk(v, 32'h0);
      s_axi_wstrb_i <= 4'hF;
      // unmapped places refuse on both paths
      axi_rd(8'h1C, v, s);
      chk({30'h0, s}, {30'h0, `ABX_RESP_SLVERR});
      chk(v, 32'h0);
      axi_wr(8'h40, 32'hFFFFFFFF, s);
      chk({30'h0, s}, {30'h0, `ABX_RESP_SLVERR});
      test_done;
   end
   // watchdog
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      mismatches++;
      test_done;
   end
endmodule // and_bitclear_branch_exec_test
